/* File: rtl/aagr_clk_div.sv */
// adc clock enable: base 60 ns tick (50 ns rounded up to three core cycles) divided by two to the gain code
`timescale 1ns/100ps
module aagr_clk_div (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic restart_i,
  input wire logic [2:0] gain_i,
  // tick out
  output logic tick_o
);

  localparam int BASE_W = $clog2(aagr_pkg::ADC_BASE_CYC + 1);
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(aagr_pkg::ADC_BASE_CYC - 1);

  logic [BASE_W-1:0] base_reg;
  logic [aagr_pkg::DIV_W-1:0] div_reg;
  logic [aagr_pkg::DIV_W-1:0] div_last;
  logic base_tick;

  // divide by 2**gain
  assign div_last = aagr_pkg::DIV_W'((8'h01 << gain_i) - 8'h01);
  assign base_tick = (base_reg == BASE_LAST);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || (ce_i && restart_i)) begin
      base_reg <= '0;
    end else if (ce_i) begin
      base_reg <= base_tick ? '0 : base_reg + BASE_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || (ce_i && restart_i)) begin
      div_reg <= '0;
    end else if (ce_i && base_tick) begin
      div_reg <= (div_reg >= div_last) ? '0 : div_reg + aagr_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= !restart_i && base_tick && (div_reg >= div_last);
    end
  end

endmodule : aagr_clk_div

/* File: rtl/aagr_pkg.sv */
// package: register map, field layout, reset values and timing of the ambient adc config block
package aagr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] VIS_GAIN_OFS = 8'h11;
  localparam logic [7:0] VIS_RNG_OFS = 8'h12;
  localparam logic [7:0] LED_RSV_OFS = 8'h1C;
  localparam logic [7:0] IR_REC_OFS = 8'h1D;
  localparam logic [7:0] IR_GAIN_OFS = 8'h1E;
  localparam logic [7:0] CTRL_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h21;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MSB = 2;
  localparam int RANGE_BIT = 5;
  localparam int REC_LSB = 4;
  localparam int REC_MSB = 6;
  localparam int CTRL_EARLY_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IR_BIT = 1;
  localparam int STAT_RECOVER_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] VIS_GAIN_RST = 8'h00;
  localparam logic [7:0] VIS_RNG_RST = 8'h00;
  localparam logic [7:0] LED_RSV_RST = 8'h00;
  localparam logic [7:0] IR_REC_RST = 8'h70;
  localparam logic [7:0] IR_GAIN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CORE_CLK_NS = 20;
  localparam int ADC_CLK_NS = 50;
  // least time, rounded up to whole core cycles
  localparam int ADC_BASE_CYC = (ADC_CLK_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam logic [2:0] GAIN_MAX = 3'h7;
  localparam int DIV_W = 7;
  localparam int REC_W = 9;

  // recovery length in adc clocks for each code
  function automatic logic [REC_W-1:0] rec_clocks(input logic [2:0] code);
    logic [REC_W-1:0] n;
    n = 9'h001;
    unique case (code)
      3'h0: n = 9'h001;
      3'h1: n = 9'h007;
      3'h2: n = 9'h00F;
      3'h3: n = 9'h01F;
      3'h4: n = 9'h03F;
      3'h5: n = 9'h07F;
      3'h6: n = 9'h0FF;
      3'h7: n = 9'h1FF;
    endcase
    return n;
  endfunction : rec_clocks

  typedef enum logic [1:0] {
    AAGR_IDLE,
    AAGR_RECOVER,
    AAGR_GO
  } aagr_state_t;

endpackage : aagr_pkg

/* File: rtl/aagr_recovery.sv */
// recovery delay: counts a coded number of adc clocks before a measurement
`timescale 1ns/100ps
module aagr_recovery (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic load_i,
  input wire logic [2:0] code_i,
  input wire logic tick_i,
  // status
  output logic busy_o,
  output logic done_o
);

  logic [aagr_pkg::REC_W-1:0] left_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      left_reg <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (load_i) begin
        left_reg <= aagr_pkg::rec_clocks(code_i);
        busy_o <= 1'b1;
      end else if (busy_o && tick_i) begin
        left_reg <= left_reg - aagr_pkg::REC_W'(1);
        if (left_reg == aagr_pkg::REC_W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule : aagr_recovery

/* File: rtl/aagr_top.sv */
// ambient adc gain, range and recovery configuration with measurement pacing
//
// Operation
// - visible integration scaled by two to gain
// - visible gain code tops at seven
// - adc clock divider equals two to gain
// - visible gain resets to zero
// - range bit five selects high range
// - early sequencer: visible gain and range govern infrared
// - infrared recovery delay from coded adc clocks
// - infrared recovery parameter resets to 0x70
// - infrared integration scaled by its own gain when the early sequencer is off
`timescale 1ns/100ps
module aagr_top (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // measurement requests
  input wire logic vis_start_i,
  input wire logic ir_start_i,
  // adc control
  output logic adc_tick_o,
  output logic [2:0] gain_code_o,
  output logic [7:0] integ_factor_o,
  output logic high_range_o,
  output logic ir_active_o,
  output logic recovering_o,
  output logic conv_start_o
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter storage
  logic [2:0] visible_gain_exponent_reg;
  logic visible_high_range_reg;
  logic [7:0] led_recovery_reserved_reg;
  logic [2:0] infrared_recovery_select_reg;
  logic [2:0] infrared_gain_exponent_reg;
  logic early_seq_reg;
  logic wr_gain_vis;
  logic wr_range_vis;
  logic wr_led_rsv;
  logic wr_rec_ir;
  logic wr_gain_ir;
  logic wr_ctrl;

  // one write select per parameter, frozen with the clock enable
  assign wr_gain_vis = ce_i && wr_i && (addr_i == aagr_pkg::VIS_GAIN_OFS);
  assign wr_range_vis = ce_i && wr_i && (addr_i == aagr_pkg::VIS_RNG_OFS);
  assign wr_led_rsv = ce_i && wr_i && (addr_i == aagr_pkg::LED_RSV_OFS);
  assign wr_rec_ir = ce_i && wr_i && (addr_i == aagr_pkg::IR_REC_OFS);
  assign wr_gain_ir = ce_i && wr_i && (addr_i == aagr_pkg::IR_GAIN_OFS);
  assign wr_ctrl = ce_i && wr_i && (addr_i == aagr_pkg::CTRL_OFS);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      visible_gain_exponent_reg <= aagr_pkg::VIS_GAIN_RST[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB];
    end else if (wr_gain_vis) begin
      // three bits hold every code up to the maximum
      visible_gain_exponent_reg <= wdata_i[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      visible_high_range_reg <= aagr_pkg::VIS_RNG_RST[aagr_pkg::RANGE_BIT];
    end else if (wr_range_vis) begin
      visible_high_range_reg <= wdata_i[aagr_pkg::RANGE_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      led_recovery_reserved_reg <= aagr_pkg::LED_RSV_RST;
    end else if (wr_led_rsv) begin
      led_recovery_reserved_reg <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      infrared_recovery_select_reg <= aagr_pkg::IR_REC_RST[aagr_pkg::REC_MSB:aagr_pkg::REC_LSB];
    end else if (wr_rec_ir) begin
      infrared_recovery_select_reg <= wdata_i[aagr_pkg::REC_MSB:aagr_pkg::REC_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      infrared_gain_exponent_reg <= aagr_pkg::IR_GAIN_RST[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB];
    end else if (wr_gain_ir) begin
      infrared_gain_exponent_reg <= wdata_i[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      early_seq_reg <= aagr_pkg::CTRL_RST[aagr_pkg::CTRL_EARLY_BIT];
    end else if (wr_ctrl) begin
      early_seq_reg <= wdata_i[aagr_pkg::CTRL_EARLY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer
  aagr_pkg::aagr_state_t state_reg;
  aagr_pkg::aagr_state_t state_next;
  logic ir_sel_reg;
  logic rec_done;
  logic rec_busy;
  logic tick;
  logic accept;
  logic [2:0] gain_sel;
  logic range_sel;
  logic [2:0] gain_pick;
  logic range_pick;
  logic [2:0] gain_hold_reg;
  logic range_hold_reg;

  assign accept = (state_reg == aagr_pkg::AAGR_IDLE) && (vis_start_i || ir_start_i);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      aagr_pkg::AAGR_IDLE: begin
        if (ir_start_i) begin
          state_next = aagr_pkg::AAGR_RECOVER;
        end else if (vis_start_i) begin
          state_next = aagr_pkg::AAGR_GO;
        end
      end
      aagr_pkg::AAGR_RECOVER: begin
        if (rec_done) begin
          state_next = aagr_pkg::AAGR_GO;
        end
      end
      aagr_pkg::AAGR_GO: begin
        state_next = aagr_pkg::AAGR_IDLE;
      end
      default: state_next = aagr_pkg::AAGR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= aagr_pkg::AAGR_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // infrared wins when both requests arrive together
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ir_sel_reg <= 1'b0;
    end else if (ce_i && accept) begin
      ir_sel_reg <= ir_start_i;
    end
  end

  // gain and range for the channel asked for by a new request
  always_comb begin
    gain_pick = visible_gain_exponent_reg;
    range_pick = visible_high_range_reg;
    if (ir_start_i) begin
      if (early_seq_reg) begin
        range_pick = visible_high_range_reg;
      end else begin
        gain_pick = infrared_gain_exponent_reg;
        range_pick = 1'b0;
      end
    end
  end

  // settings captured when a request is taken, so later writes cannot disturb a running measurement
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gain_hold_reg <= aagr_pkg::VIS_GAIN_RST[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB];
      range_hold_reg <= aagr_pkg::VIS_RNG_RST[aagr_pkg::RANGE_BIT];
    end else if (ce_i && accept) begin
      gain_hold_reg <= gain_pick;
      range_hold_reg <= range_pick;
    end
  end

  assign gain_sel = accept ? gain_pick : gain_hold_reg;
  assign range_sel = accept ? range_pick : range_hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  // adc clock and recovery delay
  aagr_clk_div u_clk_div (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .restart_i(accept),
    .gain_i(gain_sel),
    .tick_o(tick)
  );

  // each recovery clock is the gain-scaled adc clock
  aagr_recovery u_recovery (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(accept && ir_start_i),
    .code_i(infrared_recovery_select_reg),
    .tick_i(tick),
    .busy_o(rec_busy),
    .done_o(rec_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      adc_tick_o <= 1'b0;
    end else if (ce_i) begin
      adc_tick_o <= tick;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gain_code_o <= 3'h0;
      integ_factor_o <= 8'h01;
    end else if (ce_i) begin
      gain_code_o <= gain_sel;
      integ_factor_o <= 8'h01 << gain_sel;
    end
  end

  // range follows the captured channel settings
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      high_range_o <= 1'b0;
    end else if (ce_i) begin
      high_range_o <= range_sel;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ir_active_o <= 1'b0;
    end else if (ce_i) begin
      ir_active_o <= accept ? ir_start_i : ir_sel_reg;
    end
  end

  // mirrors the recovery counter, one cycle late
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      recovering_o <= 1'b0;
    end else if (ce_i) begin
      recovering_o <= rec_busy;
    end
  end

  // one-cycle pulse as the sequencer enters GO
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= (state_next == aagr_pkg::AAGR_GO);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, data in the cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      aagr_pkg::VIS_GAIN_OFS: rd_mux[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB] = visible_gain_exponent_reg;
      aagr_pkg::VIS_RNG_OFS: rd_mux[aagr_pkg::RANGE_BIT] = visible_high_range_reg;
      aagr_pkg::LED_RSV_OFS: rd_mux = led_recovery_reserved_reg;
      aagr_pkg::IR_REC_OFS: rd_mux[aagr_pkg::REC_MSB:aagr_pkg::REC_LSB] = infrared_recovery_select_reg;
      aagr_pkg::IR_GAIN_OFS: rd_mux[aagr_pkg::GAIN_MSB:aagr_pkg::GAIN_LSB] = infrared_gain_exponent_reg;
      aagr_pkg::CTRL_OFS: rd_mux[aagr_pkg::CTRL_EARLY_BIT] = early_seq_reg;
      aagr_pkg::STATUS_OFS: begin
        rd_mux[aagr_pkg::STAT_BUSY_BIT] = (state_reg != aagr_pkg::AAGR_IDLE);
        rd_mux[aagr_pkg::STAT_IR_BIT] = ir_sel_reg;
        rd_mux[aagr_pkg::STAT_RECOVER_BIT] = rec_busy;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

endmodule : aagr_top

/* File: test/aagr_host.sv */
// host model: parameter writes and reads over the register port
`timescale 1ns/100ps
module aagr_host (
  // clock and read data
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  // register port
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg
  // recovery code is the complement of the gain, reserved bits zero
  task automatic set_recovery(input logic [2:0] gain);
    wr_reg(8'h1D, {1'b0, ~gain, 4'h0});
  endtask : set_recovery
endmodule : aagr_host

/* File: test/aagr_top_bench.sv */
// testbench: register map, gain, range and recovery checks
`timescale 1ns/100ps
module aagr_top_bench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic vis_start_i = 1'b0;
  logic ir_start_i = 1'b0;
  logic [7:0] addr, wdata, rdata_o, rd_data, integ_factor_o;
  logic wr, rd, adc_tick_o, high_range_o, ir_active_o, recovering_o, conv_start_o;
  logic [2:0] gain_code_o;
  int mismatches = 0;
  int total_checks = 0;
  int n_ticks, period;
  logic rec_seen;
  aagr_top i_dut (.core_clk_i, .rst_i, .ce_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o,
    .vis_start_i, .ir_start_i, .adc_tick_o, .gain_code_o, .integ_factor_o, .high_range_o, .ir_active_o,
    .recovering_o, .conv_start_o);
  aagr_host i_host (.core_clk_i, .rdata_i(rdata_o), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd_reg(a, rd_data);
    chk("register", {8'h00, exp}, {8'h00, rd_data});
  endtask : rdchk
  task automatic wrchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    i_host.wr_reg(a, d);
    rdchk(a, exp);
  endtask : wrchk
  // request a measurement, count adc ticks until the start pulse
  task automatic meas(input logic ir);
    int t1;
    n_ticks = 0;
    rec_seen = 1'b0;
    period = 0;
    t1 = 0;
    @(posedge core_clk_i);
    vis_start_i <= ~ir;
    ir_start_i <= ir;
    @(posedge core_clk_i);
    vis_start_i <= 1'b0;
    ir_start_i <= 1'b0;
    #1;
    for (int i = 0; i < 20000 && conv_start_o !== 1'b1; i++) begin
      if (recovering_o === 1'b1) rec_seen = 1'b1;
      if (adc_tick_o === 1'b1) begin
        if (n_ticks == 1) period = i - t1;
        t1 = i;
        n_ticks++;
      end
      @(posedge core_clk_i);
      #1;
    end
    chk("start", 16'h1, {15'h0, conv_start_o});
    chk("ir active", {15'h0, ir}, {15'h0, ir_active_o});
    chk("recovering", {15'h0, ir}, {15'h0, rec_seen});
  endtask : meas
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("factor", 16'h1, {8'h0, integ_factor_o});
    rdchk(8'h11, 8'h00);
    rdchk(8'h12, 8'h00);
    rdchk(8'h1C, 8'h00);
    rdchk(8'h1D, 8'h70);
    wrchk(8'h12, 8'hFF, 8'h20);
    wrchk(8'h1C, 8'hA5, 8'hA5);
    wrchk(8'h30, 8'h55, 8'h00);
    wrchk(8'h11, 8'hFF, 8'h07);
    for (int g = 0; g < 8; g++) begin
      wrchk(8'h11, 8'(g), 8'(g));
      meas(1'b0);
      chk("vis gain", 16'(g), {13'h0, gain_code_o});
      chk("vis factor", 16'h1 << g, {8'h0, integ_factor_o});
      chk("visible_high_range", 16'h1, {15'h0, high_range_o});
    end
    wrchk(8'h12, 8'h00, 8'h00);
    meas(1'b0);
    chk("visible_high_range", 16'h0, {15'h0, high_range_o});
    for (int g = 0; g < 8; g++) begin
      i_host.wr_reg(8'h1E, 8'(g));
      i_host.set_recovery(3'(g));
      meas(1'b1);
      chk("ir gain", 16'(g), {13'h0, gain_code_o});
      chk("ticks", (g == 7) ? 16'h1 : (16'h1 << (9 - g)) - 16'h1, 16'(n_ticks));
      if (g < 7) chk("tick period", 16'h3 << g, 16'(period));
    end
    wrchk(8'h20, 8'h01, 8'h01);
    wrchk(8'h12, 8'h20, 8'h20);
    wrchk(8'h11, 8'h05, 8'h05);
    meas(1'b1);
    chk("early gain", 16'h5, {13'h0, gain_code_o});
    chk("early range", 16'h1, {15'h0, high_range_o});
    final_report();
  end
endmodule : aagr_top_bench

/* File: test/aagr_top_props.sv */
// checker: port assertions of the ambient adc config block
`timescale 1ns/100ps
module aagr_top_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic vis_start_i,
  input wire logic ir_start_i,
  input wire logic adc_tick_o,
  input wire logic [2:0] gain_code_o,
  input wire logic [7:0] integ_factor_o,
  input wire logic high_range_o,
  input wire logic ir_active_o,
  input wire logic recovering_o,
  input wire logic conv_start_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rec_end;
    $fell(recovering_o);
  endsequence
  sequence s_conv_soon;
    ##[0:1] conv_start_o;
  endsequence
  a_factor_gain: assert property (
    integ_factor_o == (8'h01 << gain_code_o)) else $error("factor not two to gain");
  a_reset_out: assert property (
    $fell(rst_i) |-> integ_factor_o == 8'h01 && gain_code_o == 3'h0 && !high_range_o) else $error("bad reset outputs");
  a_tick_single: assert property (
    adc_tick_o |=> !adc_tick_o) else $error("tick longer than one cycle");
  a_vis_conv: assert property (
    conv_start_o && !ir_active_o |-> $past(vis_start_i)) else $error("visible start without request");
  a_rec_rise: assert property (
    $rose(recovering_o) |-> $past(ir_start_i, 2) && ir_active_o) else $error("recovery without ir request");
  a_rec_conv: assert property (
    s_rec_end |-> s_conv_soon) else $error("no start after recovery");
  a_gain_hold: assert property (
    !vis_start_i && !ir_start_i |=> $stable(gain_code_o)) else $error("gain moved without request");
  a_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read cycle");
endmodule : aagr_top_props
bind aagr_top aagr_top_props i_props (.core_clk_i, .rst_i, .rd_i, .rdata_o, .vis_start_i, .ir_start_i,
  .adc_tick_o, .gain_code_o, .integ_factor_o, .high_range_o, .ir_active_o, .recovering_o, .conv_start_o);
